// >>> core/gpio_port_pin_control.sv
// 8-bit general-purpose port: control registers and pin multiplexing
// Summary of operation
// - function bit 0 gives general-purpose use; pin level readable
// - function bit 1 lets the peripheral drive data and enable
// - reset clears all function bits; each pin independent
// - direction 0 floats the output, direction 1 drives it
// - reset clears all direction bits, pins start as inputs
// - input sample is read-only and shows pin levels always
// - output value drives output pins; read returns written value
// - reset leaves the output value register untouched
// - pull-up only in general mode with output buffer off
// - reset clears all pull-up enables
// - fast slew bit 1 fast, 0 slow, in every mode
// - reset clears all fast slew bits
// - alternate choice picks peripheral, ignored unless function set
// - registers 8-bit read/write except input sample, drive state and pull-up state; bit n pin n
`timescale 1ns/100ps
`include "gpio_port_consts.svh"

module gpio_port_pin_control
  import gpio_port_pkg::*;
#(
  parameter logic [7:0] ALT1_PRESENT = `ALT1_ALL_PRESENT
) (
  input  wire logic                   clock_i,       // system clock
  input  wire logic                   sys_rst_i,     // async reset, high
  input  wire logic [3:0]             addr_i,        // register offset
  input  wire logic [7:0]             wdata_i,       // write data
  input  wire logic                   wr_i,          // write strobe
  input  wire logic                   rd_i,          // read strobe
  output logic      [7:0]             rdata_o,       // read data, +1 cycle
  input  wire logic [7:0]             pin_in_i,      // pad input levels
  output logic      [7:0]             pin_out_o,     // pad output data
  output logic      [7:0]             pin_oe_o,      // pad output enable
  output logic      [7:0]             pin_pullup_o,  // weak pull-up enable
  output logic      [7:0]             pin_fast_slew_o, // fast slew select
  input  gpio_port_pkg::periph_drive_t periph_fn0_i, // first functions
  input  gpio_port_pkg::periph_drive_t periph_fn1_i, // second functions
  output gpio_port_pkg::periph_input_t periph_in_o   // levels to functions
);

  import gpio_port_pkg::*;

  // -------------------------------------------------------------------------
  // software registers
  // -------------------------------------------------------------------------
  logic [7:0] pin_function_select;
  logic [7:0] pin_direction;
  logic [7:0] pin_output_value;
  logic [7:0] pin_pullup_enable;
  logic [7:0] pin_fast_slew;
  logic [7:0] alt_function_choice;
  logic [7:0] pin_input_sample;
  logic [7:0] next_rdata;

  logic       wr_fsel;
  logic       wr_dir;
  logic       wr_dout;
  logic       wr_pu;
  logic       wr_fast;
  logic       wr_alts;

  // -------------------------------------------------------------------------
  // write decode
  // -------------------------------------------------------------------------
  assign wr_fsel = wr_i && addr_i == `OFS_FUNCTION_SELECT;
  assign wr_dir  = wr_i && addr_i == `OFS_DIRECTION;
  assign wr_dout = wr_i && addr_i == `OFS_OUTPUT_VALUE;
  assign wr_pu   = wr_i && addr_i == `OFS_PULLUP_ENABLE;
  assign wr_fast = wr_i && addr_i == `OFS_FAST_SLEW;
  assign wr_alts = wr_i && addr_i == `OFS_ALT_CHOICE;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_function_select <= `RST_FUNCTION_SELECT;
    end else if (wr_fsel) begin
      pin_function_select <= wdata_i;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_direction <= `RST_DIRECTION;
    end else if (wr_dir) begin
      pin_direction <= wdata_i;
    end
  end

  // no reset on purpose: content survives a reset
  always_ff @(posedge clock_i) begin
    if (wr_dout) begin
      pin_output_value <= wdata_i;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_pullup_enable <= `RST_PULLUP_ENABLE;
    end else if (wr_pu) begin
      pin_pullup_enable <= wdata_i;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_fast_slew <= `RST_FAST_SLEW;
    end else if (wr_fast) begin
      pin_fast_slew <= wdata_i;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      alt_function_choice <= `RST_ALT_CHOICE;
    end else if (wr_alts) begin
      alt_function_choice <= wdata_i;
    end
  end

  // -------------------------------------------------------------------------
  // pin level sampling
  // -------------------------------------------------------------------------
  pin_sync #(
    .WIDTH (`GPIO_PORT_WIDTH)
  ) u_sync (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (pin_in_i),
    .sync_o    (pin_input_sample)
  );

  // -------------------------------------------------------------------------
  // per-pin multiplexing, each pin on its own bits
  // -------------------------------------------------------------------------
  genvar n;
  generate
    for (n = 0; n < `GPIO_PORT_WIDTH; n++) begin : g_pin
      pin_cfg_t    cfg;
      cell_drive_t fn0;
      cell_drive_t fn1;
      cell_drive_t pad;

      assign cfg.fsel = pin_function_select[n];
      assign cfg.alts = alt_function_choice[n];
      assign cfg.dir  = pin_direction[n];
      assign cfg.dout = pin_output_value[n];
      assign cfg.pu   = pin_pullup_enable[n];
      assign cfg.fast = pin_fast_slew[n];
      assign fn0.data = periph_fn0_i.data[n];
      assign fn0.oe   = periph_fn0_i.oe[n];
      assign fn1.data = periph_fn1_i.data[n];
      assign fn1.oe   = periph_fn1_i.oe[n];

      pin_cell u_cell (
        .cfg_i         (cfg),
        .fn0_i         (fn0),
        .fn1_i         (fn1),
        .fn1_present_i (ALT1_PRESENT[n]),
        .level_i       (pin_input_sample[n]),
        .pad_o         (pad),
        .pullup_o      (pin_pullup_o[n]),
        .fast_slew_o   (pin_fast_slew_o[n]),
        .fn0_in_o      (periph_in_o.fn0[n]),
        .fn1_in_o      (periph_in_o.fn1[n])
      );

      assign pin_out_o[n] = pad.data;
      assign pin_oe_o[n]  = pad.oe;
    end
  endgenerate

  // -------------------------------------------------------------------------
  // read path, data one cycle after the strobe and only then
  // -------------------------------------------------------------------------
  always_comb begin
    next_rdata = `RST_READ_DATA;
    if (rd_i) begin
      unique case (addr_i)
        `OFS_FUNCTION_SELECT: next_rdata = pin_function_select;
        `OFS_DIRECTION:       next_rdata = pin_direction;
        `OFS_INPUT_SAMPLE:    next_rdata = pin_input_sample;
        `OFS_OUTPUT_VALUE:    next_rdata = pin_output_value;
        `OFS_PULLUP_ENABLE:   next_rdata = pin_pullup_enable;
        `OFS_FAST_SLEW:       next_rdata = pin_fast_slew;
        `OFS_ALT_CHOICE:      next_rdata = alt_function_choice;
        `OFS_DRIVE_STATE:     next_rdata = pin_oe_o;
        `OFS_PULLUP_STATE:    next_rdata = pin_pullup_o;
        default:              next_rdata = `RST_READ_DATA;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= `RST_READ_DATA;
    end else begin
      rdata_o <= next_rdata;
    end
  end

endmodule : gpio_port_pin_control

// >>> core/pin_cell.sv
// per-pin selection between general-purpose and peripheral control
`timescale 1ns/100ps

module pin_cell
  import gpio_port_pkg::*;
(
  input  gpio_port_pkg::pin_cfg_t    cfg_i,         // software settings
  input  gpio_port_pkg::cell_drive_t fn0_i,         // first function drive
  input  gpio_port_pkg::cell_drive_t fn1_i,         // second function drive
  input  wire logic                  fn1_present_i, // second choice exists
  input  wire logic                  level_i,       // synchronised level
  output gpio_port_pkg::cell_drive_t pad_o,         // pin data and enable
  output logic                       pullup_o,      // weak pull-up on
  output logic                       fast_slew_o,   // fast slew select
  output logic                       fn0_in_o,      // level to function 0
  output logic                       fn1_in_o       // level to function 1
);

  cell_drive_t drive;

  // -------------------------------------------------------------------------
  // output source selection
  // -------------------------------------------------------------------------
  always_comb begin
    if (!cfg_i.fsel) begin
      drive.oe   = cfg_i.dir;
      drive.data = cfg_i.dout;
    end else if (!cfg_i.alts) begin
      drive = fn0_i;
    end else if (fn1_present_i) begin
      drive = fn1_i;
    end else begin
      // reserved second choice: the pin floats
      drive = '0;
    end
  end

  // masking keeps an unwritten output value off the pin
  assign pad_o.oe   = drive.oe;
  assign pad_o.data = drive.oe & drive.data;

  assign pullup_o    = ~cfg_i.fsel & cfg_i.pu & ~cfg_i.dir;
  assign fast_slew_o = cfg_i.fast;

  assign fn0_in_o = cfg_i.fsel & ~cfg_i.alts & level_i;
  assign fn1_in_o = cfg_i.fsel & cfg_i.alts & fn1_present_i
                    & level_i;

endmodule : pin_cell

// >>> core/pin_sync.sv
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/100ps
`include "gpio_port_consts.svh"

module pin_sync #(
  parameter int WIDTH = `GPIO_PORT_WIDTH
) (
  input  wire logic             clock_i,   // system clock
  input  wire logic             sys_rst_i, // async reset, active high
  input  wire logic [WIDTH-1:0] async_i,   // raw pin levels
  output logic      [WIDTH-1:0] sync_o     // synchronised levels
);

  logic [WIDTH-1:0] stage1;

  // -------------------------------------------------------------------------
  // first stage is read only by the second
  // -------------------------------------------------------------------------
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule : pin_sync

// >>> dv/gpio_port_pin_control_bench.sv
// self-checking bench of the gpio port control block
`timescale 1ns/100ps
module gpio_port_pin_control_bench;
  import gpio_port_pkg::*;
  localparam logic [7:0] ALT1 = 8'h7F; // pin 7 has no second function
  logic          clock_i, sys_rst_i, wr_i, rd_i;
  logic [3:0]    addr_i;
  logic [7:0]    wdata_i, rdata_o, pin_in_i, pin_out_o, pin_oe_o;
  logic [7:0]    pin_pullup_o, pin_fast_slew_o, ext, ext_oe;
  periph_drive_t fn0, fn1;
  periph_input_t to_fn;
  int            miscompares = 0;
  int            check_count = 0;

  gpio_port_pin_control #(.ALT1_PRESENT(ALT1)) u_gpio_port_pin_control (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .pin_pullup_o(pin_pullup_o), .pin_fast_slew_o(pin_fast_slew_o),
    .periph_fn0_i(fn0), .periph_fn1_i(fn1), .periph_in_o(to_fn)
  );
  pad_model u_pad_model (
    .clock_i(clock_i), .out_i(pin_out_o), .oe_i(pin_oe_o),
    .pu_i(pin_pullup_o), .ext_i(ext), .ext_oe_i(ext_oe), .level_o(pin_in_i)
  );

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  // --------
  // tasks
  // --------
  task automatic chk(input string what, input logic [7:0] exp, got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
    @(posedge clock_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    {rd_i, addr_i} <= {1'b1, a};
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    chk("rdata_o", exp, rdata_o);
  endtask : rd
  task automatic pins(input logic [7:0] oe, out, pu, sl);
    chk("pin_oe_o", oe, pin_oe_o);
    chk("pin_out_o", out, pin_out_o);
    chk("pin_pullup_o", pu, pin_pullup_o);
    chk("pin_fast_slew_o", sl, pin_fast_slew_o);
  endtask : pins
  task automatic t_reset();
    logic [3:0] ra [5] = '{4'h0, 4'h2, 4'h8, 4'hA, 4'hC};
    #1;
    pins(8'h00, 8'h00, 8'h00, 8'h00);
    foreach (ra[i]) rd(ra[i], 8'h00);
    rd(4'h1, 8'h00);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_gpio();
    @(posedge clock_i);
    {ext, ext_oe} <= {8'h3C, 8'hF0};
    wr(4'h6, 8'hA5);
    wr(4'h2, 8'h0F);
    pins(8'h0F, 8'h05, 8'h00, 8'h00);
    rd(4'h6, 8'hA5);
    wr(4'h4, 8'hFF);
    rd(4'h4, 8'h35);
    wr(4'h8, 8'hFF);
    wr(4'hA, 8'h96);
    pins(8'h0F, 8'h05, 8'hF0, 8'h96);
    @(posedge clock_i);
    sys_rst_i <= 1'b1;
    @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rd(4'h6, 8'hA5);
    pins(8'h00, 8'h00, 8'h00, 8'h00);
    rd(4'h2, 8'h00);
    wr(4'h2, 8'h0F);
    wr(4'h8, 8'hFF);
    wr(4'hA, 8'h96);
    $display("t_gpio done");
  endtask : t_gpio
  task automatic t_periph();
    @(posedge clock_i);
    ext_oe <= 8'h80;
    wr(4'h0, 8'hF0);
    pins(8'h0F, 8'h05, 8'h00, 8'h96);
    wr(4'hC, 8'h41);
    pins(8'h0F, 8'h05, 8'h00, 8'h96);
    @(posedge clock_i);
    fn0 <= '{data: 8'hAA, oe: 8'hFF};
    fn1 <= '{data: 8'h55, oe: 8'hFF};
    wr(4'hC, 8'hC1);
    pins(8'h7F, 8'h65, 8'h00, 8'h96);
    repeat (2) @(posedge clock_i);
    #1;
    chk("fn0", 8'h20, to_fn.fn0);
    chk("fn1", 8'h40, to_fn.fn1);
    rd(4'h4, 8'h65);
    wr(4'h0, 8'h00);
    pins(8'h0F, 8'h05, 8'hF0, 8'h96);
    $display("t_periph done");
  endtask : t_periph
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  // about 55 cycles are needed; far more is a hang
  initial begin
    #80000;
    miscompares++;
    test_done();
  end
  initial begin
    sys_rst_i = 1'b1;
    {wr_i, rd_i, addr_i, wdata_i} = '0;
    {ext, ext_oe, fn0, fn1} = '0;
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_gpio();
    t_periph();
    test_done();
  end
endmodule : gpio_port_pin_control_bench

// >>> dv/gpio_port_pin_control_monitor.sv
// checker of the gpio port pins and read data
`timescale 1ns/100ps
module gpio_port_pin_control_monitor
  import gpio_port_pkg::*;
#(
  parameter logic [7:0] ALT1_PRESENT = 8'hFF
) (
  input wire logic       clock_i,         // clock
  input wire logic       sys_rst_i,       // reset
  input wire logic [3:0] addr_i,          // offset
  input wire logic [7:0] wdata_i,         // write data
  input wire logic       wr_i,            // write
  input wire logic       rd_i,            // read
  input wire logic [7:0] rdata_o,         // read data
  input wire logic [7:0] pin_in_i,        // pad levels
  input wire logic [7:0] pin_out_o,       // pad data
  input wire logic [7:0] pin_oe_o,        // pad enable
  input wire logic [7:0] pin_pullup_o,    // pull-up
  input wire logic [7:0] pin_fast_slew_o, // slew
  input gpio_port_pkg::periph_drive_t periph_fn0_i, // function 0
  input gpio_port_pkg::periph_drive_t periph_fn1_i, // function 1
  input gpio_port_pkg::periph_input_t periph_in_o   // to functions
);
  logic [7:0] fsel, dir, dout, pu, fast, alts, f1, s_oe, s_dat;
  logic [1:0] up;
  // shadow settings rebuilt from the write strobes
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {fsel, dir, pu, fast, alts} <= '0;
      up <= 2'h0;
    end else begin
      up <= (up == 2'h3) ? up : up + 2'h1;
      if (wr_i && addr_i == 4'h0) fsel <= wdata_i;
      if (wr_i && addr_i == 4'h2) dir <= wdata_i;
      if (wr_i && addr_i == 4'h8) pu <= wdata_i;
      if (wr_i && addr_i == 4'hA) fast <= wdata_i;
      if (wr_i && addr_i == 4'hC) alts <= wdata_i;
    end
  end
  // no reset here: the output value survives reset
  always_ff @(posedge clock_i) begin
    if (wr_i && addr_i == 4'h6) dout <= wdata_i;
  end
  assign f1 = alts & ALT1_PRESENT;
  assign s_oe = fsel & (~alts & periph_fn0_i.oe | f1 & periph_fn1_i.oe);
  assign s_dat = ~alts & periph_fn0_i.data | f1 & periph_fn1_i.data;
  // --------
  // properties
  // --------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_rd(logic [3:0] a);
    rd_i && addr_i == a;
  endsequence
  sequence s_still;
    $stable(pin_in_i) && pin_in_i == $past(pin_in_i, 2) && up == 2'h3;
  endsequence
  property p_oe; pin_oe_o == (~fsel & dir | s_oe); endproperty
  property p_gp; ((pin_out_o ^ dout) & ~fsel & dir) == 8'h00; endproperty
  property p_pe; ((pin_out_o ^ s_dat) & s_oe) == 8'h00; endproperty
  property p_rsv;
    (fsel & alts & ~ALT1_PRESENT & (pin_oe_o | periph_in_o.fn1)) == 8'h00;
  endproperty
  property p_sel;
    (periph_in_o.fn0 & ~(fsel & ~alts) | periph_in_o.fn1 & ~(fsel & f1))
      == 8'h00;
  endproperty
  property p_pu; pin_pullup_o == (pu & ~fsel & ~dir); endproperty
  property p_slew;
    wr_i && addr_i == 4'hA |=> pin_fast_slew_o == $past(wdata_i);
  endproperty
  property p_rdo; s_rd(4'h6) |=> rdata_o == $past(dout); endproperty
  property p_rdi;
    s_rd(4'h4) ##0 s_still |=> rdata_o == $past(pin_in_i);
  endproperty
  property p_idle; !rd_i |=> rdata_o == 8'h00; endproperty
  property p_rst;
    $fell(sys_rst_i) |-> (pin_oe_o | pin_pullup_o | pin_fast_slew_o) == 8'h00;
  endproperty
  a_oe: assert property (p_oe) else $error("pad enable wrong");
  a_gp: assert property (p_gp) else $error("pad data wrong");
  a_pe: assert property (p_pe) else $error("function data wrong");
  a_rsv: assert property (p_rsv) else $error("reserved pin used");
  a_sel: assert property (p_sel) else $error("level misrouted");
  a_pu: assert property (p_pu) else $error("pull-up wrong");
  a_slew: assert property (p_slew) else $error("slew wrong");
  a_rdo: assert property (p_rdo) else $error("output read wrong");
  a_rdi: assert property (p_rdi) else $error("input read wrong");
  a_idle: assert property (p_idle) else $error("read data held");
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule : gpio_port_pin_control_monitor

bind gpio_port_pin_control gpio_port_pin_control_monitor #(
  .ALT1_PRESENT(ALT1_PRESENT)
) u_mon (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
  .pin_pullup_o(pin_pullup_o), .pin_fast_slew_o(pin_fast_slew_o),
  .periph_fn0_i(periph_fn0_i), .periph_fn1_i(periph_fn1_i),
  .periph_in_o(periph_in_o)
);

// >>> dv/pad_model.sv
// board side of the eight pads: drivers, pull-ups, floating lines
`timescale 1ns/100ps
module pad_model (
  input  wire logic       clock_i,  // clock
  input  wire logic [7:0] out_i,    // device pad data
  input  wire logic [7:0] oe_i,     // device pad enable
  input  wire logic [7:0] pu_i,     // device pull-up
  input  wire logic [7:0] ext_i,    // board drive level
  input  wire logic [7:0] ext_oe_i, // board drive enable
  output logic      [7:0] level_o   // resolved level
);
  logic [7:0] flt;
  // undriven lines wander so a lost enable cannot pass
  initial begin
    flt = 8'h5A;
    forever @(posedge clock_i) flt <= ~flt;
  end
  assign level_o = oe_i & out_i | ~oe_i & ext_oe_i & ext_i
                 | ~oe_i & ~ext_oe_i & (pu_i | flt);
endmodule : pad_model

// >>> include/gpio_port_consts.svh
// register offsets, reset values and sizes of the gpio port control block
`ifndef GPIO_PORT_CONSTS_SVH
`define GPIO_PORT_CONSTS_SVH

// ---------------------------------------------------------------------------
// port geometry
// ---------------------------------------------------------------------------
`define GPIO_PORT_WIDTH     8
`define GPIO_ADDR_WIDTH     4
`define GPIO_SYNC_STAGES    2

// ---------------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------------
`define OFS_FUNCTION_SELECT 4'h0
`define OFS_DIRECTION       4'h2
`define OFS_INPUT_SAMPLE    4'h4
`define OFS_OUTPUT_VALUE    4'h6
`define OFS_PULLUP_ENABLE   4'h8
`define OFS_FAST_SLEW       4'hA
`define OFS_ALT_CHOICE      4'hC
`define OFS_DRIVE_STATE     4'hE
`define OFS_PULLUP_STATE    4'hF

// ---------------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------------
`define RST_FUNCTION_SELECT 8'h00
`define RST_DIRECTION       8'h00
`define RST_PULLUP_ENABLE   8'h00
`define RST_FAST_SLEW       8'h00
`define RST_ALT_CHOICE      8'h00
`define RST_READ_DATA       8'h00
`define RST_SYNC            8'h00
`define ALT1_ALL_PRESENT    8'hFF

`endif

// >>> include/gpio_port_pkg.sv
// types shared by the gpio port control files
package gpio_port_pkg;

  // -------------------------------------------------------------------------
  // per-pin configuration as held by software
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic fsel;
    logic alts;
    logic dir;
    logic dout;
    logic pu;
    logic fast;
  } pin_cfg_t;

  // -------------------------------------------------------------------------
  // one pin's drive: data and output enable
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic data;
    logic oe;
  } cell_drive_t;

  // -------------------------------------------------------------------------
  // one peripheral function's drive for the whole port
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] oe;
  } periph_drive_t;

  // -------------------------------------------------------------------------
  // pin levels handed to first and second peripheral functions
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] fn0;
    logic [7:0] fn1;
  } periph_input_t;

endpackage : gpio_port_pkg
